// *** inc/gate_ctrl_pkg.sv ***
// Package for the gate driver host controller: modes, pin bundles, timing.
// Assumes a 50 MHz ref_clk; all timing counts derive from it.
package gate_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int FAULT_MIN_NS = 3000;
  localparam int FAULT_MIN_CYC = (FAULT_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RESET_PULSE_NS = 3000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SETUP_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int FLT_SYNC_DEPTH = 2;

  // ----------------------------------------------------------------
  // Input configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NONINV,
    MODE_INV,
    MODE_AUTO_RESET
  } drive_mode_t;

  // Pins toward one driver
  typedef struct packed {
    logic noninv_gate_input;
    logic inv_gate_input;
    logic reset_n;
  } drv_pins_t;

endpackage

// *** src/fault_filter.sv ***
// Per-channel fault line synchroniser and falling-edge (fault onset) detector.
// Assumes the fault line is open-collector, already pulled up, active low.
module fault_filter #(
  parameter int DEPTH = gate_ctrl_pkg::FLT_SYNC_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic fault_n_in,
  output logic fault_seen,
  output logic fault_rise
);

  logic [DEPTH-1:0] sync_reg;
  logic seen_reg;

  // Two stage capture; only the last stage is examined
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_reg <= '1;
    end else begin
      sync_reg <= {sync_reg[DEPTH-2:0], fault_n_in};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= ~sync_reg[DEPTH-1];
    end
  end

  assign fault_seen = seen_reg;
  assign fault_rise = ~sync_reg[DEPTH-1] & ~seen_reg;

endmodule

// *** src/gate_ctrl.sv ***
// Host controller for a bank of isolated gate drivers with fault latch.
// Assumes drivers sample pins asynchronously; fault lines pulled up outside.
module gate_ctrl #(
  parameter int CHANNELS = 6,
  parameter int RESET_CYC = gate_ctrl_pkg::RESET_PULSE_CYC,
  parameter int SETUP_CYCLES = gate_ctrl_pkg::SETUP_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire gate_ctrl_pkg::drive_mode_t mode,
  input wire logic global_shutdown,
  input wire logic [CHANNELS-1:0] gate_cmd,
  input wire logic [CHANNELS-1:0] fault_clear_req,
  input wire logic [CHANNELS-1:0] fault_n,
  output gate_ctrl_pkg::drv_pins_t [CHANNELS-1:0] drv_pins,
  output logic [CHANNELS-1:0] fault_status,
  output logic [CHANNELS-1:0] fault_event,
  output logic [CHANNELS-1:0] reset_busy,
  output logic any_fault
);

  typedef enum {
    CH_RUN,
    CH_FAULTED,
    CH_SAFE,
    CH_RESET,
    CH_RELEASE
  } ch_state_t;

  localparam int CW = $clog2(RESET_CYC + SETUP_CYCLES + 2);
  localparam logic [CW-1:0] SETUP_LAST = CW'(SETUP_CYCLES - 1);
  localparam logic [CW-1:0] RESET_LAST = CW'(RESET_CYC - 1);

  logic [CHANNELS-1:0] seen;
  logic [CHANNELS-1:0] rise;
  logic any_fault_reg;
  logic any_next;

  // ----------------------------------------------------------------
  // Global fault summary
  // ----------------------------------------------------------------
  // wired line stops all
  assign any_next = |seen;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      any_fault_reg <= 1'b0;
    end else begin
      any_fault_reg <= any_next;
    end
  end

  assign any_fault = any_fault_reg;

  // ----------------------------------------------------------------
  // Per channel sequencer
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      ch_state_t state_reg;
      logic [CW-1:0] cnt_reg;
      logic nin_reg;
      logic inv_reg;
      logic rst_n_reg;
      logic stat_reg;
      logic evt_reg;
      logic busy_reg;
      logic on_req;
      logic gate_off;

      fault_filter u_filt (
        .ref_clk(ref_clk),
        .srst(srst),
        .fault_n_in(fault_n[g]),
        .fault_seen(seen[g]),
        .fault_rise(rise[g])
      );

      // Command forced off on any fault or global stop
      // fault forces off
      assign on_req = gate_cmd[g] & ~global_shutdown & ~any_fault_reg & (state_reg == CH_RUN);
      assign gate_off = ~on_req;

      // per-channel reset sequence
      // Busy flag kept in step with the state so the port is a flop
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          state_reg <= CH_RUN;
          cnt_reg <= '0;
          busy_reg <= 1'b0;
        end else begin
          case (state_reg)
            CH_RUN: begin
              cnt_reg <= '0;
              busy_reg <= 1'b0;
              if (seen[g] && mode != gate_ctrl_pkg::MODE_AUTO_RESET) begin
                state_reg <= CH_FAULTED;
              end
            end
            CH_FAULTED: begin
              if (fault_clear_req[g]) begin
                state_reg <= CH_SAFE;
                cnt_reg <= '0;
                busy_reg <= 1'b1;
              end
            end
            CH_SAFE: begin
              if (cnt_reg == SETUP_LAST) begin
                state_reg <= CH_RESET;
                cnt_reg <= '0;
              end else begin
                cnt_reg <= cnt_reg + 1'b1;
              end
            end
            CH_RESET: begin
              if (cnt_reg == RESET_LAST) begin
                state_reg <= CH_RELEASE;
                cnt_reg <= '0;
              end else begin
                cnt_reg <= cnt_reg + 1'b1;
              end
            end
            CH_RELEASE: begin
              // Wait for released fault line before resuming
              // A line still low after the window means a live fault
              if (!seen[g]) begin
                state_reg <= CH_RUN;
                busy_reg <= 1'b0;
              end else if (cnt_reg == RESET_LAST) begin
                state_reg <= CH_FAULTED;
                busy_reg <= 1'b0;
              end else begin
                cnt_reg <= cnt_reg + 1'b1;
              end
            end
            default: begin
              state_reg <= CH_RUN;
              busy_reg <= 1'b0;
            end
          endcase
        end
      end

      // --------------------------------------------------------------
      // Pin drivers
      // --------------------------------------------------------------
      // pins always driven push-pull
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          nin_reg <= 1'b0;
          inv_reg <= 1'b0;
        end else begin
          case (mode)
            gate_ctrl_pkg::MODE_INV: begin
              nin_reg <= 1'b1;
              inv_reg <= gate_off;
            end
            default: begin
              nin_reg <= on_req;
              inv_reg <= 1'b0;
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          rst_n_reg <= 1'b1;
        end else if (mode == gate_ctrl_pkg::MODE_AUTO_RESET) begin
          rst_n_reg <= on_req;
        end else begin
          rst_n_reg <= (state_reg != CH_RESET);
        end
      end

      // Sticky status; new fault wins over clear
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          stat_reg <= 1'b0;
          evt_reg <= 1'b0;
        end else begin
          evt_reg <= rise[g];
          if (rise[g]) begin
            stat_reg <= 1'b1;
          end else if (fault_clear_req[g]) begin
            stat_reg <= 1'b0;
          end
        end
      end

      assign drv_pins[g].noninv_gate_input = nin_reg;
      assign drv_pins[g].inv_gate_input = inv_reg;
      assign drv_pins[g].reset_n = rst_n_reg;
      assign fault_status[g] = stat_reg;
      assign fault_event[g] = evt_reg;
      assign reset_busy[g] = busy_reg;
    end
  endgenerate

endmodule

// *** verif/gate_ctrl_chk.sv ***
// Port-level assertions for gate_ctrl.
// Assumes one clock domain; counts handed on by the bind.
module gate_ctrl_chk #(
  parameter int CHANNELS = 6,
  parameter int RESET_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire gate_ctrl_pkg::drive_mode_t mode,
  input wire logic global_shutdown,
  input wire logic [CHANNELS-1:0] gate_cmd,
  input wire logic [CHANNELS-1:0] fault_clear_req,
  input wire logic [CHANNELS-1:0] fault_n,
  input wire gate_ctrl_pkg::drv_pins_t [CHANNELS-1:0] drv_pins,
  input wire logic [CHANNELS-1:0] fault_status,
  input wire logic [CHANNELS-1:0] reset_busy,
  input wire logic any_fault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [CHANNELS-1:0] off;
  logic [15:0] low_cnt_reg;
  logic run0;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      off[i] = !drv_pins[i].noninv_gate_input || drv_pins[i].inv_gate_input;
    end
  end
  assign run0 = !any_fault && !global_shutdown && !fault_status[0] && !reset_busy[0]
    && mode == gate_ctrl_pkg::MODE_NONINV;
  // Consecutive cycles with reset held low
  always_ff @(posedge ref_clk) begin
    if (srst || drv_pins[0].reset_n) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  sequence s_run;
    run0 ##1 run0;
  endsequence
  sequence s_clear;
    fault_clear_req[0] && fault_status[0] && !reset_busy[0] && mode != gate_ctrl_pkg::MODE_AUTO_RESET;
  endsequence
  AST_RST_SAFE: assert property (disable iff (1'b0) srst |=> off[0] && drv_pins[0].reset_n)
    else $error("pins not safe after reset");
  AST_NONINV_FOLLOW: assert property (s_run |-> drv_pins[0].noninv_gate_input == $past(gate_cmd[0])
    && !drv_pins[0].inv_gate_input) else $error("noninverting drive does not follow command");
  AST_INV_HIGH: assert property (mode == gate_ctrl_pkg::MODE_INV |=> drv_pins[0].noninv_gate_input)
    else $error("noninverting input not high in inverting use");
  AST_FORCED_OFF: assert property ((any_fault || global_shutdown) |=> &off)
    else $error("gate left on during fault or shutdown");
  AST_WIRED_SEEN: assert property ((!fault_n[0])[*5] |-> any_fault)
    else $error("fault line low but no fault flagged");
  AST_RESET_SAFE: assert property (!drv_pins[0].reset_n |-> off[0])
    else $error("reset asserted with output commanded on");
  AST_CLEAR_SEQ: assert property (s_clear |=> reset_busy[0] && !fault_status[0] ##[1:12] !drv_pins[0].reset_n)
    else $error("clear request did not start reset");
  AST_PULSE_LEN: assert property ($rose(drv_pins[0].reset_n) && mode != gate_ctrl_pkg::MODE_AUTO_RESET
    |-> low_cnt_reg >= RESET_CYC && low_cnt_reg <= RESET_CYC + 1) else $error("reset pulse length wrong");
endmodule
bind gate_ctrl gate_ctrl_chk #(.CHANNELS(CHANNELS), .RESET_CYC(RESET_CYC)) gate_ctrl_chk_inst (
  .ref_clk(ref_clk), .srst(srst), .mode(mode), .global_shutdown(global_shutdown), .gate_cmd(gate_cmd),
  .fault_clear_req(fault_clear_req), .fault_n(fault_n), .drv_pins(drv_pins), .fault_status(fault_status),
  .reset_busy(reset_busy), .any_fault(any_fault));

// *** verif/drv_model.sv ***
// Behavioural model of one isolated gate driver, input side view.
// Assumes a pull-up on the fault line: released reads high.
module drv_model (
  input wire gate_ctrl_pkg::drv_pins_t pins,
  input wire logic collector_sat_sense,
  output logic fault_n,
  output logic gate_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt = 1'b0;
  always @(pins or collector_sat_sense) begin
    if (!pins.reset_n) begin
      flt = 1'b0;
    end else if (collector_sat_sense && pins.noninv_gate_input && !pins.inv_gate_input) begin
      flt = 1'b1;
    end
  end
  assign gate_out = pins.noninv_gate_input && !pins.inv_gate_input && !flt;
  assign fault_n = !flt;
endmodule

// *** verif/gate_ctrl_test.sv ***
// Self-checking bench: gate_ctrl driving two modelled gate drivers.
// Assumes shortened reset and setup counts, one 50 MHz clock.
module gate_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  gate_ctrl_pkg::drive_mode_t mode = gate_ctrl_pkg::MODE_NONINV;
  logic global_shutdown = 1'b0;
  logic [1:0] gate_cmd = 2'h0;
  logic [1:0] fault_clear_req = 2'h0;
  logic [1:0] collector_sat_sense = 2'h0;
  logic [1:0] fault_n, gate_out, fault_status, fault_event, reset_busy;
  gate_ctrl_pkg::drv_pins_t [1:0] drv_pins;
  logic any_fault;
  int fail_count = 0;
  int checks = 0;
  int i;
  always #10 ref_clk = ~ref_clk;
  gate_ctrl #(.CHANNELS(2), .RESET_CYC(4), .SETUP_CYCLES(2)) gate_ctrl_inst (.ref_clk(ref_clk), .srst(srst),
    .mode(mode), .global_shutdown(global_shutdown), .gate_cmd(gate_cmd), .fault_clear_req(fault_clear_req),
    .fault_n(fault_n), .drv_pins(drv_pins), .fault_status(fault_status), .fault_event(fault_event),
    .reset_busy(reset_busy), .any_fault(any_fault));
  for (genvar g = 0; g < 2; g++) begin : gen_drv
    drv_model drv_model_inst (.pins(drv_pins[g]), .collector_sat_sense(collector_sat_sense[g]), .fault_n(fault_n[g]), .gate_out(gate_out[g]));
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic test_modes;
    gate_cmd = 2'h1;
    tick(2);
    check(drv_pins[0].inv_gate_input, 1'b0);
    check(gate_out[0], 1'b1);
    mode = gate_ctrl_pkg::MODE_INV;
    gate_cmd = 2'h0;
    tick(2);
    check(drv_pins[0].noninv_gate_input, 1'b1);
    check(gate_out[0], 1'b0);
    global_shutdown = 1'b1;
    gate_cmd = 2'h3;
    tick(2);
    check(gate_out[1], 1'b0);
    global_shutdown = 1'b0;
    mode = gate_ctrl_pkg::MODE_NONINV;
    tick(2);
    check(gate_out[1], 1'b1);
    $display("modes test done");
  endtask
  // Fault on one driver, local clear while command still on
  task automatic test_local_reset;
    collector_sat_sense[0] = 1'b1;
    tick(1);
    collector_sat_sense[0] = 1'b0;
    for (i = 0; i < 20 && fault_event[0] !== 1'b1; i++) tick(1);
    check(fault_event[0], 1'b1);
    // Summary flop, then the other channel's pin flop
    tick(2);
    check(fault_status[0], 1'b1);
    check(gate_out[1], 1'b0);
    fault_clear_req[0] = 1'b1;
    tick(1);
    fault_clear_req[0] = 1'b0;
    check(fault_n[0], 1'b0);
    for (i = 0; i < 20 && drv_pins[0].reset_n !== 1'b0; i++) tick(1);
    check(drv_pins[0].noninv_gate_input, 1'b0);
    for (i = 0; i < 40 && reset_busy[0] !== 1'b0; i++) tick(1);
    tick(4);
    check(fault_n[0], 1'b1);
    check(gate_out[0], 1'b1);
    $display("local reset test done");
  endtask
  // Reset follows gate command in auto mode
  task automatic test_auto;
    mode = gate_ctrl_pkg::MODE_AUTO_RESET;
    tick(3);
    collector_sat_sense[0] = 1'b1;
    tick(1);
    collector_sat_sense[0] = 1'b0;
    gate_cmd = 2'h0;
    check(fault_n[0], 1'b0);
    tick(2);
    check(drv_pins[0].reset_n, 1'b0);
    check(fault_n[0], 1'b1);
    gate_cmd = 2'h1;
    tick(10);
    check(gate_out[0], 1'b1);
    $display("auto test done");
  endtask
  initial begin
    tick(4);
    srst = 1'b0;
    tick(1);
    test_modes;
    test_local_reset;
    test_auto;
    complete_run;
  end
  initial begin
    #40000;
    fail_count++;
    complete_run;
  end
endmodule
